// ---- verilog/pipeline_interlock.sv ----
/*
 * Interlock, slip and operand forwarding control for the integer pipe,
 * plus spacing windows for system-control hazards and an Avalon-MM slave.
 * Assumes the fetch unit offers descriptors on the core clock and that
 * the register file writes through in writeback.
 */
`timescale 1ns/1ps
module pipeline_interlock #(
    parameter logic [3:0] ISTR_STORE_SPACING = pipe_ctrl_pkg::SPC_ISTR_STORE
) (
    // clock and reset
    input  wire logic                  CLOCK,
    input  wire logic                  RESETN,
    // fetch side
    input  pipe_ctrl_pkg::instr_t      FETCH_INSTR,
    output logic                       FETCH_READY,
    // pipeline control
    output logic                       E_ADVANCE,
    output logic                       E_SLIP,
    output pipe_ctrl_pkg::fwd_sel_t    FWD_SEL_A,
    output pipe_ctrl_pkg::fwd_sel_t    FWD_SEL_B,
    // writeback
    output logic                       WB_VALID,
    output logic [4:0]                 WB_DST,
    // register bus
    input  wire logic [3:0]            AVS_ADDRESS,
    input  wire logic                  AVS_READ,
    input  wire logic                  AVS_WRITE,
    input  wire logic [31:0]           AVS_WRITEDATA,
    input  wire logic [3:0]            AVS_BYTEENABLE,
    output logic [31:0]                AVS_READDATA,
    output logic                       AVS_WAITREQUEST
);

    localparam logic [pipe_ctrl_pkg::N_FETCH-1:0][pipe_ctrl_pkg::SPC_W-1:0] FETCH_SPACING =
        {ISTR_STORE_SPACING, pipe_ctrl_pkg::FETCH_SPACING_FIXED};

    pipe_ctrl_pkg::instr_t i_q;
    pipe_ctrl_pkg::instr_t e_q;
    pipe_ctrl_pkg::instr_t m_q;
    pipe_ctrl_pkg::instr_t a_q;
    pipe_ctrl_pkg::instr_t w_q;
    logic                                 bypass_en;
    logic [31:0]                          slip_count;
    logic                                 ack;
    logic                                 load_use;
    logic                                 nobyp_wait;
    logic                                 exec_wait;
    logic [pipe_ctrl_pkg::N_EXEC-1:0]     exec_start;
    logic [pipe_ctrl_pkg::N_EXEC-1:0]     exec_busy;
    logic [pipe_ctrl_pkg::N_FETCH-1:0]    fetch_start;
    logic [pipe_ctrl_pkg::N_FETCH-1:0]    fetch_busy;
    logic [31:0]                          next_readdata;

    // older stage p produces src; register 0 is never a dependency
    function automatic logic hits(input logic [4:0] src, input pipe_ctrl_pkg::instr_t p);
        return p.valid && p.wr && (p.dst == src) && (src != 5'h00);
    endfunction : hits

    function automatic pipe_ctrl_pkg::fwd_sel_t pick(input logic [4:0] src,
                                                     input pipe_ctrl_pkg::instr_t m,
                                                     input pipe_ctrl_pkg::instr_t a,
                                                     input logic en);
        pipe_ctrl_pkg::fwd_sel_t sel;
        sel = pipe_ctrl_pkg::FWD_REGFILE;
        if (en && hits(src, m)) begin
            // a load in memory has no data yet; the slip covers it
            sel = m.load ? pipe_ctrl_pkg::FWD_REGFILE : pipe_ctrl_pkg::FWD_FROM_M;
        end else if (en && hits(src, a)) begin
            sel = pipe_ctrl_pkg::FWD_FROM_A;
        end
        return sel;
    endfunction : pick

    // every term below is looked at in every cycle
    // loads forward from align only, so a load in memory blocks
    assign load_use   = m_q.load && (hits(e_q.src_a, m_q) || hits(e_q.src_b, m_q));
    // with forwarding off, wait until the producer reaches writeback
    assign nobyp_wait = !bypass_en && (hits(e_q.src_a, m_q) || hits(e_q.src_b, m_q)
                                    || hits(e_q.src_a, a_q) || hits(e_q.src_b, a_q));
    // system-control dependents wait out their window
    assign exec_wait  = |(e_q.needs & exec_busy);
    // execute releases only with all sources available
    assign E_SLIP     = e_q.valid && (load_use || nobyp_wait || exec_wait);
    assign E_ADVANCE  = e_q.valid && !E_SLIP;
    // fetch is held by hardware while a fetch window is open
    assign FETCH_READY = !E_SLIP && !(|fetch_busy);

    // an ALU result in memory is forwarded, no slip
    assign FWD_SEL_A = pick(e_q.src_a, m_q, a_q, bypass_en);
    assign FWD_SEL_B = pick(e_q.src_b, m_q, a_q, bypass_en);

    // fetch and execute hold together on a slip
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            i_q <= '0;
            e_q <= '0;
        end else if (!E_SLIP) begin
            i_q <= (FETCH_READY && FETCH_INSTR.valid) ? FETCH_INSTR : '0;
            e_q <= i_q;
        end
    end

    // older stages always move; a slip puts a bubble in memory
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            m_q <= '0;
            a_q <= '0;
            w_q <= '0;
        end else begin
            m_q <= E_SLIP ? '0 : e_q;
            a_q <= m_q;
            w_q <= a_q;
        end
    end

    assign WB_VALID = w_q.valid && w_q.wr;
    assign WB_DST   = w_q.dst;

    // hazard windows start as the writer leaves execute
    always_comb begin
        exec_start  = '0;
        fetch_start = '0;
        if (E_ADVANCE) begin
            unique case (e_q.creates)
                pipe_ctrl_pkg::WR_USABLE: begin
                    exec_start[pipe_ctrl_pkg::EX_USABLE] = 1'b1;
                end
                pipe_ctrl_pkg::WR_SOFTINT: begin
                    exec_start[pipe_ctrl_pkg::EX_SOFTINT]  = 1'b1;
                    fetch_start[pipe_ctrl_pkg::FE_SOFTINT] = 1'b1;
                end
                pipe_ctrl_pkg::WR_COMPARE: begin
                    exec_start[pipe_ctrl_pkg::EX_TIMER] = 1'b1;
                end
                pipe_ctrl_pkg::WR_OTHER: begin
                    exec_start[pipe_ctrl_pkg::EX_OTHER] = 1'b1;
                end
                pipe_ctrl_pkg::WR_ADDRESS_SPACE_ID: begin
                    exec_start[pipe_ctrl_pkg::EX_XLATE]  = 1'b1;
                    fetch_start[pipe_ctrl_pkg::FE_ADDRESS_SPACE_ID]  = 1'b1;
                end
                // status is also an ordinary register for execution
                pipe_ctrl_pkg::WR_STATUS: begin
                    exec_start[pipe_ctrl_pkg::EX_OTHER]   = 1'b1;
                    fetch_start[pipe_ctrl_pkg::FE_STATUS] = 1'b1;
                end
                pipe_ctrl_pkg::WR_TLB: begin
                    fetch_start[pipe_ctrl_pkg::FE_TLB] = 1'b1;
                end
                pipe_ctrl_pkg::WR_ISTR_CACHE: begin
                    fetch_start[pipe_ctrl_pkg::FE_ISTR_CACHE] = 1'b1;
                end
                pipe_ctrl_pkg::WR_ISTR_STORE: begin
                    fetch_start[pipe_ctrl_pkg::FE_ISTR_STORE] = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // one window per hazard class
    for (genvar g = 0; g < pipe_ctrl_pkg::N_EXEC; g++) begin : g_exec
        hazard_window #(
            .SPC_W   (pipe_ctrl_pkg::SPC_W),
            .SPACING (pipe_ctrl_pkg::EXEC_SPACING[g])
        ) u_win (
            .clk   (CLOCK),
            .rst_n (RESETN),
            .start (exec_start[g]),
            .busy  (exec_busy[g])
        );
    end
    for (genvar g = 0; g < pipe_ctrl_pkg::N_FETCH; g++) begin : g_fetch
        hazard_window #(
            .SPC_W   (pipe_ctrl_pkg::SPC_W),
            .SPACING (FETCH_SPACING[g])
        ) u_win (
            .clk   (CLOCK),
            .rst_n (RESETN),
            .start (fetch_start[g]),
            .busy  (fetch_busy[g])
        );
    end

    // bus: one wait cycle, then the answer; write lands on the ack edge
    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack;
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            ack <= 1'b0;
        end else begin
            ack <= (AVS_READ || AVS_WRITE) && !ack;
        end
    end

    // control register; only the low byte lane carries a field
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            bypass_en <= pipe_ctrl_pkg::CTRL_BYPASS_RST;
        end else if (AVS_WRITE && ack && AVS_ADDRESS == pipe_ctrl_pkg::ADDR_CTRL
                     && AVS_BYTEENABLE[0]) begin
            bypass_en <= AVS_WRITEDATA[pipe_ctrl_pkg::CTRL_BYPASS_BIT];
        end
    end

    // slip counter; a slip in the clearing cycle still counts
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            slip_count <= pipe_ctrl_pkg::SLIPCNT_RST;
        end else if (AVS_WRITE && ack && AVS_ADDRESS == pipe_ctrl_pkg::ADDR_SLIPCNT) begin
            slip_count <= {31'h0000_0000, E_SLIP};
        end else if (E_SLIP) begin
            slip_count <= slip_count + 32'h0000_0001;
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        next_readdata = 32'h0000_0000;
        unique case (AVS_ADDRESS)
            pipe_ctrl_pkg::ADDR_CTRL: begin
                next_readdata[pipe_ctrl_pkg::CTRL_BYPASS_BIT] = bypass_en;
            end
            pipe_ctrl_pkg::ADDR_STATUS: begin
                next_readdata[pipe_ctrl_pkg::ST_EXEC_LSB +: pipe_ctrl_pkg::N_EXEC] = exec_busy;
                next_readdata[pipe_ctrl_pkg::ST_FETCH_LSB +: pipe_ctrl_pkg::N_FETCH] = fetch_busy;
                next_readdata[pipe_ctrl_pkg::ST_SLIP_BIT] = E_SLIP;
            end
            pipe_ctrl_pkg::ADDR_SLIPCNT: begin
                next_readdata = slip_count;
            end
            default: begin
            end
        endcase
    end

    // data captured in the wait cycle so it stands on the ack edge
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            AVS_READDATA <= 32'h0000_0000;
        end else if (AVS_READ && !ack) begin
            AVS_READDATA <= next_readdata;
        end
    end

    // checks
    a_stage_order: assert property (@(posedge CLOCK) disable iff (!RESETN)
        (!E_SLIP [*2]) |-> ##3 (w_q == $past(i_q, 4)))
        else $error("instruction did not reach writeback in stage order");
    a_slip_bubble: assert property (@(posedge CLOCK) disable iff (!RESETN)
        E_SLIP |=> (e_q == $past(e_q)) && !m_q.valid && (a_q == $past(m_q)))
        else $error("slip did not hold execute and bubble memory");
    a_load_slip: assert property (@(posedge CLOCK) disable iff (!RESETN)
        (e_q.valid && m_q.load && hits(e_q.src_a, m_q)) |-> E_SLIP && !E_ADVANCE)
        else $error("load result used from memory stage");
    a_alu_chain: assert property (@(posedge CLOCK) disable iff (!RESETN)
        (e_q.valid && bypass_en && !exec_wait && !m_q.load && hits(e_q.src_a, m_q)
         && !hits(e_q.src_b, m_q)) |-> !E_SLIP && FWD_SEL_A == pipe_ctrl_pkg::FWD_FROM_M)
        else $error("dependent ALU op slipped");
    a_younger_wins: assert property (@(posedge CLOCK) disable iff (!RESETN)
        (bypass_en && !m_q.load && hits(e_q.src_a, m_q) && hits(e_q.src_a, a_q))
        |-> FWD_SEL_A == pipe_ctrl_pkg::FWD_FROM_M)
        else $error("older align result chosen over memory");
    a_align_forward: assert property (@(posedge CLOCK) disable iff (!RESETN)
        (bypass_en && !hits(e_q.src_b, m_q) && hits(e_q.src_b, a_q))
        |-> FWD_SEL_B == pipe_ctrl_pkg::FWD_FROM_A)
        else $error("align result not forwarded");
    a_usable_gap: assert property (@(posedge CLOCK) disable iff (!RESETN)
        exec_start[pipe_ctrl_pkg::EX_USABLE] ##1
        (e_q.valid && e_q.needs[pipe_ctrl_pkg::EX_USABLE]) |-> E_SLIP)
        else $error("coprocessor op ran right after usable bit write");
    a_softint_gap: assert property (@(posedge CLOCK) disable iff (!RESETN)
        E_ADVANCE && e_q.creates == pipe_ctrl_pkg::WR_SOFTINT
        |=> exec_busy[pipe_ctrl_pkg::EX_SOFTINT] [*3])
        else $error("soft interrupt window shorter than three slots");
    a_timer_gap: assert property (@(posedge CLOCK) disable iff (!RESETN)
        exec_start[pipe_ctrl_pkg::EX_TIMER] |=> exec_busy[pipe_ctrl_pkg::EX_TIMER] [*4])
        else $error("timer window shorter than four slots");
    a_tlb_fetch: assert property (@(posedge CLOCK) disable iff (!RESETN)
        fetch_start[pipe_ctrl_pkg::FE_TLB] |=> !FETCH_READY [*3])
        else $error("fetch resumed early after translation write");
    a_exec_guard: assert property (@(posedge CLOCK) disable iff (!RESETN)
        E_ADVANCE |-> !(|(e_q.needs & exec_busy)) && !load_use)
        else $error("instruction left execute with operands unready");

    c_load_slip: cover property (@(posedge CLOCK) disable iff (!RESETN) load_use && E_SLIP);
    c_fwd_m:     cover property (@(posedge CLOCK) disable iff (!RESETN)
        E_ADVANCE && FWD_SEL_A == pipe_ctrl_pkg::FWD_FROM_M);
    c_fetch_hold: cover property (@(posedge CLOCK) disable iff (!RESETN)
        (|fetch_busy) && FETCH_INSTR.valid);
    c_bus_read:  cover property (@(posedge CLOCK) disable iff (!RESETN)
        AVS_READ && !AVS_WAITREQUEST);

endmodule : pipeline_interlock

// ---- verilog/pipe_ctrl_pkg.sv ----
/*
 * Shared constants and types for the pipeline interlock and bypass control.
 * Assumes a single core clock and one register bus master.
 */
// How it works
// - five stages in order: fetch, execute, memory, align, writeback
// - hardware alone finds and resolves every interlock, no software help
// - interlock terms are evaluated each cycle for all stages holding work
// - interlocks are slips: older stages advance, blocked part holds
// - execute releases an instruction only when all sources are ready
// - execute takes sources from memory or align stage results
// - load data forwards from align only; a load in memory forces a slip
// - an ALU op using the previous ALU result does not slip
// - dependent ALU ops still issue one per clock through forwarding
// - sequential model; system-control hazards are met by enforced spacing
// - usable-bit write seen by dependent coprocessor op one slot later
// - soft interrupt bits: execution sees after 3 slots, fetch after 2
// - compare write clearing timer interrupt takes effect after 4 slots
// - any other system register write needs 2 slots before dependents
// - address space id: probes and memory ops after 1, fetch after 3
// - translation entry write seen by fetch after 3 slots
// - stream write via cache seen by fetch after 3; via store system set
// - status write, incl. error level change, holds later fetches
package pipe_ctrl_pkg;

    // what a system-side instruction writes when it leaves execute
    typedef enum logic [3:0] {
        WR_NONE       = 4'h0,
        WR_USABLE     = 4'h1,
        WR_SOFTINT    = 4'h2,
        WR_COMPARE    = 4'h3,
        WR_OTHER      = 4'h4,
        WR_ADDRESS_SPACE_ID       = 4'h5,
        WR_STATUS     = 4'h6,
        WR_TLB        = 4'h7,
        WR_ISTR_CACHE = 4'h8,
        WR_ISTR_STORE = 4'h9
    } hazard_src_t;

    // operand source for the execute stage
    typedef enum logic [1:0] {
        FWD_REGFILE = 2'h0,
        FWD_FROM_M  = 2'h1,
        FWD_FROM_A  = 2'h2
    } fwd_sel_t;

    // per-stage instruction descriptor; register 0 means no operand
    typedef struct packed {
        logic        valid;
        logic        wr;
        logic [4:0]  dst;
        logic [4:0]  src_a;
        logic [4:0]  src_b;
        logic        load;
        hazard_src_t creates;
        logic [4:0]  needs;
    } instr_t;

    // execution hazard classes (bit index into needs)
    localparam int N_EXEC     = 5;
    localparam int EX_USABLE  = 0;
    localparam int EX_SOFTINT = 1;
    localparam int EX_TIMER   = 2;
    localparam int EX_OTHER   = 3;
    localparam int EX_XLATE   = 4;

    // fetch hazard classes
    localparam int N_FETCH       = 6;
    localparam int FE_SOFTINT    = 0;
    localparam int FE_ADDRESS_SPACE_ID       = 1;
    localparam int FE_TLB        = 2;
    localparam int FE_ISTR_CACHE = 3;
    localparam int FE_STATUS     = 4;
    localparam int FE_ISTR_STORE = 5;

    // spacing in instruction slots
    localparam int SPC_W = 4;
    localparam logic [SPC_W-1:0] SPC_USABLE        = 4'h1;
    localparam logic [SPC_W-1:0] SPC_SOFTINT_EXEC  = 4'h3;
    localparam logic [SPC_W-1:0] SPC_SOFTINT_FETCH = 4'h2;
    localparam logic [SPC_W-1:0] SPC_COMPARE       = 4'h4;
    localparam logic [SPC_W-1:0] SPC_OTHER         = 4'h2;
    localparam logic [SPC_W-1:0] SPC_ADDRESS_SPACE_ID_EXEC     = 4'h1;
    localparam logic [SPC_W-1:0] SPC_ADDRESS_SPACE_ID_FETCH    = 4'h3;
    localparam logic [SPC_W-1:0] SPC_TLB_FETCH     = 4'h3;
    // stream write via cache, and default via store
    localparam logic [SPC_W-1:0] SPC_ISTR_CACHE    = 4'h3;
    localparam logic [SPC_W-1:0] SPC_ISTR_STORE    = 4'h3;
    localparam logic [SPC_W-1:0] SPC_STATUS_FETCH  = 4'h2;

    localparam logic [N_EXEC-1:0][SPC_W-1:0] EXEC_SPACING =
        {SPC_ADDRESS_SPACE_ID_EXEC, SPC_OTHER, SPC_COMPARE, SPC_SOFTINT_EXEC, SPC_USABLE};
    localparam logic [N_FETCH-2:0][SPC_W-1:0] FETCH_SPACING_FIXED =
        {SPC_STATUS_FETCH, SPC_ISTR_CACHE, SPC_TLB_FETCH, SPC_ADDRESS_SPACE_ID_FETCH, SPC_SOFTINT_FETCH};

    // register map, byte addresses
    localparam int             ADDR_W       = 4;
    localparam logic [ADDR_W-1:0] ADDR_CTRL    = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS  = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_SLIPCNT = 4'h8;
    localparam int             CTRL_BYPASS_BIT = 0;
    localparam logic           CTRL_BYPASS_RST = 1'b1;
    localparam int             ST_EXEC_LSB  = 0;
    localparam int             ST_FETCH_LSB = 8;
    localparam int             ST_SLIP_BIT  = 16;
    localparam logic [31:0]    SLIPCNT_RST  = 32'h0000_0000;

endpackage : pipe_ctrl_pkg

// ---- verilog/hazard_window.sv ----
/*
 * One spacing window: after a start pulse it stays busy for SPACING cycles.
 * Assumes every cycle moves one slot (instruction or bubble) out of execute.
 */
`timescale 1ns/1ps
module hazard_window #(
    parameter int                SPC_W   = 4,
    parameter logic [SPC_W-1:0]  SPACING = 4'h1
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // window control
    input  wire logic start,
    output logic      busy
);

    logic [SPC_W-1:0] remain;

    // a restart reloads; the pipe never halts, so slots equal cycles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            remain <= '0;
        end else if (start) begin
            remain <= SPACING;
        end else if (remain != '0) begin
            remain <= remain - 1'b1;
        end
    end

    assign busy = (remain != '0);

endmodule : hazard_window

// ---- dv/testbench.sv ----
/*
 * Self-checking bench for the interlock block: forwarding, slips,
 * spacing windows and the register bus. Drives every port itself.
 */
`timescale 1ns/1ps
module testbench;
    // clock, reset, pipe side
    logic                    CLOCK = 1'b0;
    logic                    RESETN = 1'b0;
    pipe_ctrl_pkg::instr_t   FETCH_INSTR = '0;
    logic                    FETCH_READY, E_ADVANCE, E_SLIP, WB_VALID;
    pipe_ctrl_pkg::fwd_sel_t FWD_SEL_A, FWD_SEL_B;
    logic [4:0]              WB_DST;
    // register bus
    logic [3:0]              AVS_ADDRESS = 4'h0;
    logic                    AVS_READ = 1'b0;
    logic                    AVS_WRITE = 1'b0;
    logic [31:0]             AVS_WRITEDATA = 32'h0;
    logic [3:0]              AVS_BYTEENABLE = 4'hf;
    logic [31:0]             AVS_READDATA;
    logic                    AVS_WAITREQUEST;
    int                      error_cnt = 0;
    int                      checks = 0;
    int                      n_slip, n_hold;
    logic [31:0]             rd;

    always #12.5 CLOCK = ~CLOCK;

    // store spacing set apart from the cache value so both are seen
    pipeline_interlock #(.ISTR_STORE_SPACING(4'h5)) i_pipeline_interlock (
        .CLOCK(CLOCK), .RESETN(RESETN), .FETCH_INSTR(FETCH_INSTR),
        .FETCH_READY(FETCH_READY), .E_ADVANCE(E_ADVANCE), .E_SLIP(E_SLIP),
        .FWD_SEL_A(FWD_SEL_A), .FWD_SEL_B(FWD_SEL_B), .WB_VALID(WB_VALID),
        .WB_DST(WB_DST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
        .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    // one access; waitrequest sampled on the rising edge, data taken there
    task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd,
                       input logic [3:0] be);
        int n;
        AVS_ADDRESS <= adr;
        AVS_WRITEDATA <= wd;
        AVS_BYTEENABLE <= be;
        AVS_READ <= !wr;
        AVS_WRITE <= wr;
        for (n = 0; n < 20; n++) begin
            @(posedge CLOCK);
            if (AVS_WAITREQUEST === 1'b0) break;
        end
        if (n == 20) begin
            chk("bus wait", 0, 1);
            conclude();
        end
        rd = AVS_READDATA;
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
        @(posedge CLOCK);
    endtask : bus

    // offer held until taken; left standing for the next offer
    task automatic offer(input pipe_ctrl_pkg::instr_t x);
        int n;
        FETCH_INSTR <= x;
        for (n = 0; n < 20; n++) begin
            @(posedge CLOCK);
            if (FETCH_READY === 1'b1) break;
        end
        if (n == 20) begin
            chk("fetch wait", 0, 1);
            conclude();
        end
    endtask : offer

    function automatic pipe_ctrl_pkg::instr_t mk(input logic [4:0] d, sa, sb, input logic ld,
            input pipe_ctrl_pkg::hazard_src_t c, input logic [4:0] nd);
        mk = '{valid: 1'b1, wr: (d != 5'h0), dst: d, src_a: sa, src_b: sb, load: ld,
               creates: c, needs: nd};
    endfunction : mk

    // writer then dependent back to back; slips and fetch holds counted
    task automatic hazard(input pipe_ctrl_pkg::hazard_src_t c, input logic [4:0] nd,
                          input int sl, input int hold);
        n_slip = 0;
        n_hold = 0;
        fork
            begin
                offer(mk(5'h1, 5'h0, 5'h0, 1'b0, c, 5'h0));
                offer(mk(5'h2, 5'h0, 5'h0, 1'b0, pipe_ctrl_pkg::WR_NONE, nd));
                FETCH_INSTR.valid <= 1'b0;
            end
            begin
                repeat (2) @(posedge CLOCK);
                repeat (12) begin
                    @(negedge CLOCK);
                    n_slip += (E_SLIP === 1'b1);
                    n_hold += (FETCH_READY === 1'b0);
                end
            end
        join
        @(posedge CLOCK);
        chk("slip cycles", n_slip, sl);
        chk("fetch hold cycles", n_hold, hold);
    endtask : hazard

    initial begin
        repeat (2) @(posedge CLOCK);
        RESETN <= 1'b1;
        @(posedge CLOCK);
        bus(0, pipe_ctrl_pkg::ADDR_CTRL, 0, 4'hf);
        chk("ctrl", rd, 32'h1);
        bus(0, pipe_ctrl_pkg::ADDR_STATUS, 0, 4'hf);
        chk("status", rd, 32'h0);
        bus(1, 4'hc, 32'hffff_ffff, 4'hf);
        bus(0, 4'hc, 0, 4'hf);
        chk("unmapped", rd, 32'h0);
        $display("test registers done");
        // a r3, b r3<-r3, c r6<-r3, d r7<-r3,r6 issued one per clock
        fork
            begin
                offer(mk(5'h3, 5'h0, 5'h0, 1'b0, pipe_ctrl_pkg::WR_NONE, 5'h0));
                offer(mk(5'h3, 5'h3, 5'h9, 1'b0, pipe_ctrl_pkg::WR_NONE, 5'h0));
                offer(mk(5'h6, 5'h3, 5'h0, 1'b0, pipe_ctrl_pkg::WR_NONE, 5'h0));
                offer(mk(5'h7, 5'h3, 5'h6, 1'b0, pipe_ctrl_pkg::WR_NONE, 5'h0));
                FETCH_INSTR.valid <= 1'b0;
            end
            begin
                // b taken into fetch at edge 2, in execute after edge 3
                repeat (3) @(posedge CLOCK);
                @(negedge CLOCK);
                chk("b fwd a", FWD_SEL_A, pipe_ctrl_pkg::FWD_FROM_M);
                chk("b fwd b", FWD_SEL_B, pipe_ctrl_pkg::FWD_REGFILE);
                chk("b advance", E_ADVANCE, 1'b1);
                @(negedge CLOCK);
                chk("c fwd a", FWD_SEL_A, pipe_ctrl_pkg::FWD_FROM_M);
                chk("c advance", E_ADVANCE, 1'b1);
                @(negedge CLOCK);
                chk("d fwd a", FWD_SEL_A, pipe_ctrl_pkg::FWD_FROM_A);
                chk("d fwd b", FWD_SEL_B, pipe_ctrl_pkg::FWD_FROM_M);
                @(negedge CLOCK);
                chk("wb valid", WB_VALID, 1'b1);
                chk("wb dst", WB_DST, 5'h3);
            end
        join
        @(posedge CLOCK);
        $display("test forwarding done");
        // load then user: one slip, then align bypass
        fork
            begin
                offer(mk(5'h5, 5'h0, 5'h0, 1'b1, pipe_ctrl_pkg::WR_NONE, 5'h0));
                offer(mk(5'h8, 5'h5, 5'h0, 1'b0, pipe_ctrl_pkg::WR_NONE, 5'h0));
                FETCH_INSTR.valid <= 1'b0;
            end
            begin
                repeat (3) @(posedge CLOCK);
                @(negedge CLOCK);
                chk("load slip", E_SLIP, 1'b1);
                chk("fetch held", FETCH_READY, 1'b0);
                chk("no advance", E_ADVANCE, 1'b0);
                @(negedge CLOCK);
                chk("load fwd", FWD_SEL_A, pipe_ctrl_pkg::FWD_FROM_A);
                chk("load advance", E_ADVANCE, 1'b1);
            end
        join
        @(posedge CLOCK);
        bus(0, pipe_ctrl_pkg::ADDR_SLIPCNT, 0, 4'hf);
        chk("slip count", rd, 32'h1);
        bus(1, pipe_ctrl_pkg::ADDR_SLIPCNT, 32'h5, 4'hf);
        bus(0, pipe_ctrl_pkg::ADDR_SLIPCNT, 0, 4'hf);
        chk("slip clear", rd, 32'h0);
        $display("test load done");
        // bypass off: lane 0 disabled write is refused, full write lands
        bus(1, pipe_ctrl_pkg::ADDR_CTRL, 32'h0, 4'he);
        bus(0, pipe_ctrl_pkg::ADDR_CTRL, 0, 4'hf);
        chk("ctrl kept", rd, 32'h1);
        bus(1, pipe_ctrl_pkg::ADDR_CTRL, 32'h0, 4'hf);
        bus(0, pipe_ctrl_pkg::ADDR_CTRL, 0, 4'hf);
        chk("ctrl cleared", rd, 32'h0);
        hazard(pipe_ctrl_pkg::WR_NONE, 5'h0, 0, 0);
        fork
            begin
                offer(mk(5'h3, 5'h0, 5'h0, 1'b0, pipe_ctrl_pkg::WR_NONE, 5'h0));
                offer(mk(5'h4, 5'h3, 5'h0, 1'b0, pipe_ctrl_pkg::WR_NONE, 5'h0));
                FETCH_INSTR.valid <= 1'b0;
            end
            begin
                // dependent in execute after edge 3, producer leaves align at edge 5
                repeat (4) @(negedge CLOCK);
                chk("no bypass slip", E_SLIP, 1'b1);
                repeat (2) @(negedge CLOCK);
                chk("no bypass release", E_ADVANCE, 1'b1);
            end
        join
        repeat (8) @(posedge CLOCK);
        bus(1, pipe_ctrl_pkg::ADDR_CTRL, 32'h1, 4'hf);
        $display("test bypass done");
        // spacing windows: slips equal exec spacing, fetch holds the longer
        hazard(pipe_ctrl_pkg::WR_USABLE, 5'h01, 1, 1);
        hazard(pipe_ctrl_pkg::WR_SOFTINT, 5'h02, 3, 3);
        hazard(pipe_ctrl_pkg::WR_COMPARE, 5'h04, 4, 4);
        hazard(pipe_ctrl_pkg::WR_OTHER, 5'h08, 2, 2);
        hazard(pipe_ctrl_pkg::WR_ADDRESS_SPACE_ID, 5'h10, 1, 3);
        hazard(pipe_ctrl_pkg::WR_STATUS, 5'h08, 2, 2);
        hazard(pipe_ctrl_pkg::WR_TLB, 5'h00, 0, 3);
        hazard(pipe_ctrl_pkg::WR_ISTR_CACHE, 5'h00, 0, 3);
        hazard(pipe_ctrl_pkg::WR_ISTR_STORE, 5'h00, 0, 5);
        $display("test spacing done");
        conclude();
    end
endmodule : testbench
